// ==== design/smc_mode_control.sv ====
`timescale 1ns/10ps
`include "smc_regs.svh"

module smc_mode_control #(
    parameter int DUTY_W = 8,
    parameter logic [DUTY_W-1:0] DUTY_MIN = 8'h08, // RL24
    parameter logic [DUTY_W-1:0] DUTY_STEP = 8'h04, // RL24
    parameter int HOLD_PERIODS = 16, // RL24
    parameter int LAG_LONG_CYC = `SMC_LAG_LONG_CYC,
    parameter int LAG_SHORT_CYC = `SMC_LAG_SHORT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System side
    input wire smc_pkg::smc_mode_t sysMode,
    input wire smc_pkg::smc_fault_t faultIn,
    input wire logic [3:0] supplyBelowTh,
    input wire logic [3:0] supplyAboveHyst,
    input wire logic loadAboveTh,
    input wire logic wakeInputPin,
    input wire logic periodTick,
    input wire logic outputAtTarget,
    // Regulator controls
    output logic buckEnable,
    output logic buckPwm,
    output logic buckClosedLoop,
    output logic [DUTY_W-1:0] buckDuty,
    output logic buckFullDutyAllow,
    output logic stepUpOn,
    output logic stepUpPwm,
    output logic upshiftEvent
);

    // Lag counter width; holds the long lag at the nominal clock
    localparam int LAG_W = 20;
    // Hold counter width; far above any sensible period count
    localparam int HOLD_W = 16;
    // Highest duty code; the ramp never wraps past it
    localparam logic [DUTY_W-1:0] DUTY_TOP = '1;

    // Software state
    smc_pkg::smc_ctrl_t ctrl;
    // Flags kept until software clears them
    logic [`SMC_STICKY_N-1:0] sticky;
    logic [`SMC_STICKY_N-1:0] stickySet;

    // Mode tracking
    smc_pkg::smc_mode_t prevMode;
    logic inStop;
    logic stopEntry;
    logic modeOn;
    // Cycles left before upshift watching
    logic [LAG_W-1:0] lagCnt;
    logic lagDone;
    logic upshiftLatched;
    logic upshiftSet;
    // Modulation wanted for the next cycle
    logic next_pwm;

    // Soft start
    smc_pkg::smc_ss_t ssState;
    // Counts periods within one hold interval
    logic [HOLD_W-1:0] holdCnt;
    logic holdDone;

    // Bus decode
    logic busAccess;
    logic wrEn;
    logic addrOk;
    logic ctrlWr;
    logic selChangeLocked;
    logic rearm;
    logic [31:0] next_prdata;

    // Combinational mode decode
    // Stop entry is one cycle long, taken against the registered mode
    always_comb begin
        // Stop mode and its first cycle
        inStop = (sysMode == smc_pkg::SMC_STOP);
        stopEntry = inStop && (prevMode != smc_pkg::SMC_STOP);
        // Regulator powered in normal, stop and restart
        modeOn = (sysMode == smc_pkg::SMC_NORMAL) || inStop
            || (sysMode == smc_pkg::SMC_RESTART); // RL1
        // Watching starts once the lag has run out; a rearm restarts it
        lagDone = inStop && !stopEntry && !rearm && (lagCnt == '0);
        // Last period of a hold interval
        holdDone = periodTick && (holdCnt == HOLD_W'(HOLD_PERIODS - 1));
    end

    // APB decode; a write acts on the edge where pready is seen high
    // The first access cycle loads the answer, the second completes it
    always_comb begin
        // First access cycle and completing write
        busAccess = psel && penable && !pready;
        wrEn = psel && penable && pready && pwrite;
        // Only the four aligned words are mapped
        addrOk = (paddr == `SMC_CTRL_OFS) || (paddr == `SMC_STOPCMD_OFS)
            || (paddr == `SMC_STATUS_OFS) || (paddr == `SMC_DUTY_OFS);
        ctrlWr = wrEn && (paddr == `SMC_CTRL_OFS);
        // A selection change with step-up enabled is refused
        selChangeLocked = ctrlWr && ctrl.stepUpEn
            && (pwdata[`SMC_CTRL_VSEL_HI:`SMC_CTRL_VSEL_LO] != ctrl.vSel); // RL14
        rearm = wrEn && (paddr == `SMC_STOPCMD_OFS) && inStop; // RL21
    end

    // Read data mux
    // Status mixes sticky flags with the live regulator state
    always_comb begin
        // Unused bits read as zero
        next_prdata = 32'h00000000;
        case (paddr)
            `SMC_CTRL_OFS: begin
                next_prdata[5:0] = ctrl;
            end
            `SMC_STATUS_OFS: begin
                next_prdata[`SMC_STICKY_N-1:0] = sticky;
                next_prdata[`SMC_ST_BUCK_EN] = buckEnable;
                next_prdata[`SMC_ST_PWM] = buckPwm;
                next_prdata[`SMC_ST_CLOSED] = buckClosedLoop;
                next_prdata[`SMC_ST_UP_ON] = stepUpOn;
            end
            `SMC_DUTY_OFS: begin
                next_prdata[DUTY_W-1:0] = buckDuty;
            end
            default: begin
                // Unmapped places read as zero
                next_prdata = 32'h00000000;
            end
        endcase
    end

    // APB answer: ready one cycle into the access phase
    // pready stands one cycle, so back-to-back transfers need no gap
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= busAccess;
            if (busAccess) begin
                // Error flag rides with pready
                pslverr <= !addrOk || (paddr[1:0] != 2'h0);
                prdata <= next_prdata;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Control register; a locked selection change drops the whole write
    // Writes land only at the completing edge of the transfer
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= `SMC_CTRL_RESET;
        end else if (ctrlWr && !selChangeLocked) begin
            // Step-up enable and output selection
            ctrl.stepUpEn <= pwdata[`SMC_CTRL_STEPUP_EN]; // RL11
            ctrl.vSel <= pwdata[`SMC_CTRL_VSEL_HI:`SMC_CTRL_VSEL_LO]; // RL11
            ctrl.autoUp <= pwdata[`SMC_CTRL_AUTO_UP];
            ctrl.pinUp <= pwdata[`SMC_CTRL_PIN_UP];
            ctrl.dlySel <= pwdata[`SMC_CTRL_DLY_SEL];
        end
    end

    // Events feeding the sticky status bits
    // Flags only report; none of them touches mode or configuration
    always_comb begin
        stickySet = '0;
        stickySet[`SMC_ST_SW_OPEN] = faultIn.swNodeOpen; // RL9
        stickySet[`SMC_ST_SW_SHORT] = faultIn.swNodeShort; // RL9
        stickySet[`SMC_ST_UP_OPEN] = faultIn.stepUpOpen; // RL10
        stickySet[`SMC_ST_UP_SHORT] = faultIn.stepUpShort; // RL10
        stickySet[`SMC_ST_GND_LOSS] = faultIn.gndLoss; // RL10
        stickySet[`SMC_ST_UP_ACTIVE] = stepUpOn; // RL13
        stickySet[`SMC_ST_UPSHIFT] = upshiftSet; // RL20
        stickySet[`SMC_ST_CMD_ERR] = selChangeLocked; // RL14
    end

    // Sticky bits, write one to clear; a set in the same cycle wins
    generate
        for (genvar i = 0; i < `SMC_STICKY_N; i++) begin : gSticky
            always_ff @(posedge clk) begin
                if (rst) begin
                    sticky[i] <= 1'b0;
                    // A fresh event outranks the clear
                end else if (stickySet[i]) begin
                    sticky[i] <= 1'b1;
                    // Cleared by writing one to the status word
                end else if (wrEn && (paddr == `SMC_STATUS_OFS) && pwdata[i]) begin
                    sticky[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Previous mode for entry detection
    // Resetting to sleep makes stop at power-up count as an entry
    always_ff @(posedge clk) begin
        if (rst) begin
            prevMode <= smc_pkg::SMC_SLEEP;
        end else begin
            prevMode <= sysMode;
        end
    end

    // Lag before automatic upshift watching; reloaded by stop entry or rearm
    // The length is taken from the select bit at the reload
    always_ff @(posedge clk) begin
        if (rst) begin
            lagCnt <= '0;
        end else if (stopEntry || rearm) begin
            lagCnt <= ctrl.dlySel ? LAG_W'(LAG_LONG_CYC - 1) : LAG_W'(LAG_SHORT_CYC - 1); // RL23
        end else if (lagCnt != '0) begin
            lagCnt <= lagCnt - LAG_W'(1);
        end
    end

    // Automatic upshift holds until a new stop command
    always_comb begin
        upshiftSet = inStop && ctrl.autoUp && lagDone && loadAboveTh && !upshiftLatched; // RL20
    end

    // Upshift latch; cleared outside stop, on entry and by a rearm
    always_ff @(posedge clk) begin
        if (rst) begin
            upshiftLatched <= 1'b0;
        end else if (upshiftSet) begin
            upshiftLatched <= 1'b1; // RL20
        end else if (!inStop || stopEntry || rearm) begin
            upshiftLatched <= 1'b0; // RL21
        end
    end

    // One-cycle event for the interrupt collector
    // The latch blocks a second set, so it pulses once per upshift
    always_ff @(posedge clk) begin
        if (rst) begin
            upshiftEvent <= 1'b0;
        end else begin
            upshiftEvent <= upshiftSet; // RL20
        end
    end

    // Modulation choice per system mode
    always_comb begin
        case (sysMode)
            smc_pkg::SMC_NORMAL: begin
                next_pwm = 1'b1; // RL16
            end
            smc_pkg::SMC_RESTART: begin
                next_pwm = 1'b1; // RL2
            end
            smc_pkg::SMC_STOP: begin
                // Entry cycle forces PFM before any policy applies
                if (stopEntry) begin
                    next_pwm = 1'b0; // RL4
                end else if (ctrl.autoUp) begin
                    next_pwm = upshiftLatched; // RL18
                end else if (ctrl.pinUp) begin
                    next_pwm = wakeInputPin; // RL22
                end else begin
                    next_pwm = 1'b0; // RL19
                end
            end
            default: begin
                // Sleep and fail-safe leave the regulator off
                next_pwm = 1'b0;
            end
        endcase
    end

    // Step-down enable and modulation outputs
    // Both follow the mode one cycle late
    always_ff @(posedge clk) begin
        if (rst) begin
            buckEnable <= 1'b0;
            buckPwm <= 1'b0;
        end else begin
            buckEnable <= modeOn; // RL1
            buckPwm <= modeOn && next_pwm; // RL17
        end
    end

    // Soft-start sequencer; disabled regulator returns to idle
    always_ff @(posedge clk) begin
        if (rst) begin
            ssState <= smc_pkg::SS_IDLE;
            holdCnt <= '0;
            buckDuty <= '0;
        end else if (!modeOn) begin
            ssState <= smc_pkg::SS_IDLE; // RL5
            holdCnt <= '0;
            buckDuty <= '0;
        end else begin
            case (ssState)
                // Start from the minimum duty with the loop open
                smc_pkg::SS_IDLE: begin
                    ssState <= smc_pkg::SS_OPEN; // RL5
                    holdCnt <= '0;
                    buckDuty <= DUTY_MIN; // RL6
                end
                // Hold the minimum duty for the set number of periods
                smc_pkg::SS_OPEN: begin
                    if (periodTick) begin
                        holdCnt <= holdDone ? '0 : holdCnt + HOLD_W'(1); // RL6
                    end
                    if (holdDone) begin
                        ssState <= smc_pkg::SS_RAMP;
                    end
                end
                smc_pkg::SS_RAMP: begin
                    if (outputAtTarget) begin
                        ssState <= smc_pkg::SS_CLOSED; // RL8
                    end else if (periodTick) begin
                        holdCnt <= holdDone ? '0 : holdCnt + HOLD_W'(1);
                        // Step up by one increment, never past the top code
                        if (holdDone && (buckDuty <= DUTY_TOP - DUTY_STEP)) begin
                            buckDuty <= buckDuty + DUTY_STEP; // RL7
                        end
                    end
                end
                // Loop stays closed until the regulator is switched off
                smc_pkg::SS_CLOSED: begin
                    ssState <= smc_pkg::SS_CLOSED;
                end
                default: begin
                    ssState <= smc_pkg::SS_IDLE;
                end
            endcase
        end
    end

    // Loop closure and full-duty permission
    // Full duty only with the loop closed and PWM selected
    always_ff @(posedge clk) begin
        if (rst) begin
            buckClosedLoop <= 1'b0;
            buckFullDutyAllow <= 1'b0;
        end else begin
            buckClosedLoop <= modeOn && (ssState == smc_pkg::SS_CLOSED); // RL8
            buckFullDutyAllow <= modeOn && next_pwm
                && (ssState == smc_pkg::SS_CLOSED); // RL3
        end
    end

    // Step-up threshold control with hysteresis
    // Only the comparator pair of the selected output is used
    always_ff @(posedge clk) begin
        if (rst) begin
            stepUpOn <= 1'b0;
            stepUpPwm <= 1'b0;
        end else begin
            stepUpPwm <= 1'b1; // RL15
            if (!(ctrl.stepUpEn && modeOn)) begin
                stepUpOn <= 1'b0;
                // Falling below the threshold wins over the hysteresis
            end else if (supplyBelowTh[ctrl.vSel]) begin
                stepUpOn <= 1'b1; // RL12
            end else if (supplyAboveHyst[ctrl.vSel]) begin
                stepUpOn <= 1'b0; // RL12
            end
        end
    end

endmodule

// ==== design/smc_regs.svh ====
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
// Notes on behaviour
// RL1: Step-down on in normal, stop, restart only.
// RL2: PWM fixed frequency; normal, restart, stop upshift.
// RL3: PWM allows full-period high-side on; code allows it only once the loop is closed.
// RL4: Stop entry switches step-down to PFM.
// RL5: Soft start at power-up, sleep/fail-safe restart.
// RL6: Open loop at minimum duty, held periods.
// RL7: Duty rises by fixed steps until target.
// RL8: Target reached closes the regulation loop.
// RL9: Switch-node open/short flags change nothing else.
// RL10: Step-up pin faults and ground loss flagged.
// RL11: Software enables step-up, selects one of four.
// RL12: Step-up follows selected threshold with hysteresis.
// RL13: Step-up activation sets the active flag.
// RL14: Selection change while enabled: error, discarded.
// RL15: Step-up always fixed-frequency PWM.
// RL16: Normal mode runs step-down in PWM.
// RL17: Stop policy: PFM, automatic, or wake pin.
// RL18: Automatic upshift beats pin-driven setting.
// RL19: Both cleared keeps PFM through stop.
// RL20: Load above threshold upshifts, event, flag.
// RL21: Host rewrites stop command to return PFM.
// RL22: Wake pin level selects PFM or PWM directly.
// RL23: Delay select picks 1 ms or 100 us.
// RL24: Soft-start duty, step, hold are parameters.

// Register byte offsets
`define SMC_CTRL_OFS 8'h00
`define SMC_STOPCMD_OFS 8'h04
`define SMC_STATUS_OFS 8'h08
`define SMC_DUTY_OFS 8'h0C

// Control register fields
`define SMC_CTRL_STEPUP_EN 0
`define SMC_CTRL_VSEL_LO 1
`define SMC_CTRL_VSEL_HI 2
`define SMC_CTRL_AUTO_UP 3
`define SMC_CTRL_PIN_UP 4
`define SMC_CTRL_DLY_SEL 5
`define SMC_CTRL_RESET 6'h00

// Status register fields; bits below STICKY_N are write-one-to-clear
`define SMC_STICKY_N 8
`define SMC_ST_SW_OPEN 0
`define SMC_ST_SW_SHORT 1
`define SMC_ST_UP_OPEN 2
`define SMC_ST_UP_SHORT 3
`define SMC_ST_GND_LOSS 4
`define SMC_ST_UP_ACTIVE 5
`define SMC_ST_UPSHIFT 6
`define SMC_ST_CMD_ERR 7
`define SMC_ST_BUCK_EN 8
`define SMC_ST_PWM 9
`define SMC_ST_CLOSED 10
`define SMC_ST_UP_ON 11

// Timing
`define SMC_CLK_MHZ 250
`define SMC_LAG_LONG_US 1000
`define SMC_LAG_SHORT_US 100
`define SMC_LAG_LONG_CYC (`SMC_LAG_LONG_US * `SMC_CLK_MHZ)
`define SMC_LAG_SHORT_CYC (`SMC_LAG_SHORT_US * `SMC_CLK_MHZ)
`endif

// ==== design/smc_pkg.sv ====
package smc_pkg;
    // System mode from the mode controller
    typedef enum logic [2:0] {
        SMC_NORMAL = 3'h0,
        SMC_STOP = 3'h1,
        SMC_RESTART = 3'h2,
        SMC_SLEEP = 3'h3,
        SMC_FAILSAFE = 3'h4
    } smc_mode_t;

    // Soft-start sequencer states
    typedef enum logic [3:0] {
        SS_IDLE = 4'h1,
        SS_OPEN = 4'h2,
        SS_RAMP = 4'h4,
        SS_CLOSED = 4'h8
    } smc_ss_t;

    // Pin fault detectors
    typedef struct packed {
        logic gndLoss;
        logic stepUpShort;
        logic stepUpOpen;
        logic swNodeShort;
        logic swNodeOpen;
    } smc_fault_t;

    // Software control fields
    typedef struct packed {
        logic dlySel;
        logic pinUp;
        logic autoUp;
        logic [1:0] vSel;
        logic stepUpEn;
    } smc_ctrl_t;
endpackage

// ==== verif/smc_plant.sv ====
`timescale 1ns/10ps
// Power stage stand-in: period ticks and target detect
module smc_plant #(
    parameter int TICK_DIV = 4,
    parameter logic [7:0] TARGET = 8'h10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic buckEnable,
    input wire logic [7:0] buckDuty,
    output logic periodTick,
    output logic outputAtTarget
);
    logic [3:0] tickCnt; // Cycles within a period
    // Period divider with a one-cycle tick
    always_ff @(posedge clk) begin
        if (rst || tickCnt == 4'(TICK_DIV - 1)) begin
            tickCnt <= 4'h0;
        end else begin
            tickCnt <= tickCnt + 4'h1;
        end
        periodTick <= !rst && tickCnt == 4'h0;
    end
    // Output at target once duty is high enough
    always_ff @(posedge clk) begin
        outputAtTarget <= !rst && buckEnable && buckDuty >= TARGET;
    end
endmodule

// ==== verif/smc_mode_control_props.sv ====
`timescale 1ns/10ps
// Port checks of the regulator control
module smc_props #(
    parameter int DUTY_W = 8,
    parameter logic [DUTY_W-1:0] DUTY_STEP = 8'h04
) (
    input wire logic clk,
    input wire logic rst,
    input wire smc_pkg::smc_mode_t sysMode,
    input wire logic outputAtTarget,
    input wire logic buckEnable,
    input wire logic buckPwm,
    input wire logic buckClosedLoop,
    input wire logic [DUTY_W-1:0] buckDuty,
    input wire logic buckFullDutyAllow,
    input wire logic stepUpPwm,
    input wire logic upshiftEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Normal mode held long enough to settle
    sequence inNormal;
        (sysMode == smc_pkg::SMC_NORMAL)[*4];
    endsequence
    // Duty moved while open loop and enabled
    sequence rampStep;
        !buckClosedLoop && buckEnable && $past(buckEnable) && $past(buckDuty) != 0 && buckDuty != $past(buckDuty);
    endsequence
    en_by_mode_a: assert property (!$past(rst) |-> buckEnable == ($past(sysMode) < 3'h3))
        else $error("enable does not follow mode");
    normal_pwm_a: assert property (inNormal ##0 buckClosedLoop |-> buckPwm)
        else $error("no PWM in normal mode");
    full_duty_a: assert property (buckClosedLoop && buckPwm && $past(buckClosedLoop && buckPwm) |-> buckFullDutyAllow)
        else $error("full duty not allowed");
    up_pwm_a: assert property (!$past(rst) |-> stepUpPwm)
        else $error("step-up not in PWM");
    ev_pulse_a: assert property (upshiftEvent |=> !upshiftEvent && buckPwm)
        else $error("bad upshift event");
    ev_stop_a: assert property (upshiftEvent |-> $past(sysMode) == smc_pkg::SMC_STOP)
        else $error("upshift outside stop");
    ramp_step_a: assert property (rampStep |-> buckDuty == $past(buckDuty) + DUTY_STEP)
        else $error("wrong duty step");
    loop_close_a: assert property ($rose(buckClosedLoop) |-> $past(outputAtTarget))
        else $error("loop closed early");
endmodule

bind smc_mode_control smc_props #(.DUTY_W(DUTY_W), .DUTY_STEP(DUTY_STEP)) u_props (
    .clk(clk), .rst(rst), .sysMode(sysMode), .outputAtTarget(outputAtTarget), .buckEnable(buckEnable),
    .buckPwm(buckPwm), .buckClosedLoop(buckClosedLoop), .buckDuty(buckDuty),
    .buckFullDutyAllow(buckFullDutyAllow), .stepUpPwm(stepUpPwm), .upshiftEvent(upshiftEvent));

// ==== verif/smc_mode_control_tb.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
`define WAIT(c) while ((c) !== 1'b1) @(posedge clk);

// Self-checking bench of the regulator control
module smc_mode_control_tb;
    logic clk = 1'b0, rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, slvErr; // APB answer
    smc_pkg::smc_mode_t sysMode = smc_pkg::SMC_NORMAL;
    smc_pkg::smc_fault_t faultIn = 5'h00;
    logic [3:0] supplyBelowTh = 4'h0, supplyAboveHyst = 4'h0;
    logic loadAboveTh = 1'b0, wakeInputPin = 1'b0;
    logic periodTick, outputAtTarget; // From the stage model
    logic buckEnable, buckPwm, buckClosedLoop, buckFullDutyAllow, stepUpOn, stepUpPwm, upshiftEvent;
    logic [7:0] buckDuty;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    smc_pkg::smc_mode_t offMode [2] = '{smc_pkg::SMC_SLEEP, smc_pkg::SMC_FAILSAFE};

    smc_mode_control #(.HOLD_PERIODS(2), .LAG_LONG_CYC(40), .LAG_SHORT_CYC(10)) u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysMode(sysMode),
        .faultIn(faultIn), .supplyBelowTh(supplyBelowTh), .supplyAboveHyst(supplyAboveHyst),
        .loadAboveTh(loadAboveTh), .wakeInputPin(wakeInputPin), .periodTick(periodTick),
        .outputAtTarget(outputAtTarget), .buckEnable(buckEnable), .buckPwm(buckPwm),
        .buckClosedLoop(buckClosedLoop), .buckDuty(buckDuty), .buckFullDutyAllow(buckFullDutyAllow),
        .stepUpOn(stepUpOn), .stepUpPwm(stepUpPwm), .upshiftEvent(upshiftEvent));
    smc_plant u_plant (.clk(clk), .rst(rst), .buckEnable(buckEnable), .buckDuty(buckDuty),
        .periodTick(periodTick), .outputAtTarget(outputAtTarget));

    always #2 clk = ~clk; // 4 ns period

    // One APB transfer, answer kept in rdata and slvErr
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        slvErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Re-arm stop modulation, then time the automatic upshift
    task upshift(input logic [31:0] c, input int lag);
        int n;
        logic ev;
        apb(1'b1, 8'h00, c);
        loadAboveTh <= 1'b0;
        apb(1'b1, 8'h04, 32'h0);
        loadAboveTh <= 1'b1;
        ev = 1'b0;
        repeat (3) @(posedge clk);
        `CHK(buckPwm, 1'b0)
        for (n = 3; n < 100 && buckPwm !== 1'b1; n++) begin
            @(posedge clk);
            ev |= upshiftEvent;
        end
        @(posedge clk);
        ev |= upshiftEvent;
        `CHK(n >= lag - 2 && n <= lag + 6, 1'b1)
        `CHK(ev, 1'b1)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rdata[6], 1'b1)
    endtask

    // Counts, verdict and end of run
    task final_report();
        $display("Errors %0d in %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Power-up soft start
        `WAIT(buckEnable)
        @(posedge clk);
        `CHK(buckDuty, 8'h08)
        `CHK(buckClosedLoop, 1'b0)
        `WAIT(buckClosedLoop)
        `CHK(buckDuty, 8'h10)
        `CHK(buckPwm, 1'b1)
        `CHK(buckFullDutyAllow, 1'b1)
        `CHK(stepUpPwm, 1'b1)
        // Defaults, duty readback, unmapped place
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdata, 32'h0)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rdata, 32'h10)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(slvErr, 1'b1)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rdata[10:8], 3'h7)
        // Step-up follows the selected comparator only
        apb(1'b1, 8'h00, 32'h5);
        supplyBelowTh <= 4'hB;
        repeat (4) @(posedge clk);
        `CHK(stepUpOn, 1'b0)
        supplyBelowTh <= 4'h4;
        repeat (4) @(posedge clk);
        `CHK(stepUpOn, 1'b1)
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rdata, 32'h5)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rdata[7:5], 3'h5)
        supplyBelowTh <= 4'h0;
        supplyAboveHyst <= 4'h4;
        repeat (4) @(posedge clk);
        `CHK(stepUpOn, 1'b0)
        // Fault flags latch with no side effect
        apb(1'b1, 8'h08, 32'hFF);
        faultIn <= 5'h15;
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rdata[7:0], 8'h15)
        `CHK(buckEnable, 1'b1)
        faultIn <= 5'h0A;
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rdata[4:0], 5'h1F)
        `CHK(buckPwm, 1'b1)
        faultIn <= 5'h00;
        // Stop mode policies
        apb(1'b1, 8'h00, 32'h4);
        apb(1'b1, 8'h00, 32'h0);
        sysMode <= smc_pkg::SMC_STOP;
        wakeInputPin <= 1'b1;
        loadAboveTh <= 1'b1;
        repeat (60) @(posedge clk);
        `CHK(buckPwm, 1'b0)
        `CHK(buckEnable, 1'b1)
        `CHK(buckFullDutyAllow, 1'b0)
        apb(1'b1, 8'h00, 32'h10);
        repeat (3) @(posedge clk);
        `CHK(buckPwm, 1'b1)
        wakeInputPin <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(buckPwm, 1'b0)
        wakeInputPin <= 1'b1;
        for (int i = 0; i < 2; i++) upshift(i ? 32'h28 : 32'h18, i ? 40 : 10);
        // Off modes, then soft start on restart
        foreach (offMode[i]) begin
            sysMode <= offMode[i];
            repeat (3) @(posedge clk);
            `CHK(buckEnable, 1'b0)
            sysMode <= smc_pkg::SMC_RESTART;
            `WAIT(buckEnable)
            @(posedge clk);
            `CHK(buckDuty, 8'h08)
            `WAIT(buckClosedLoop)
            `CHK(buckPwm, 1'b1)
        end
        sysMode <= smc_pkg::SMC_NORMAL;
        repeat (4) @(posedge clk);
        `CHK(buckPwm, 1'b1)
        // Stop entry from normal drops to PFM during the lag
        sysMode <= smc_pkg::SMC_STOP;
        repeat (5) @(posedge clk);
        `CHK(buckPwm, 1'b0)
        final_report();
    end
endmodule
